// ==== hw/dcs_pkg.sv ====
// Purpose: Shared constants and types for the daisy-chain serial command port.
// Assumes: Frame bits arrive MSB first, one per serial clock falling edge.
// Notes:   Edge numbers count serial clock falling edges from the start of a frame.
package dcs_pkg;

    // ------------------------------------------------------------------
    // Frame timing
    // ------------------------------------------------------------------
    localparam int         SYNC_STAGES     = 3;
    localparam int         EDGE_W          = 5;
    localparam logic [4:0] EDGE_CMD        = 5'h03;
    localparam logic [4:0] EDGE_RESP_FIRST = 5'h04;
    localparam logic [4:0] EDGE_RESP_LAST  = 5'h0D;
    localparam logic [4:0] EDGE_CFG_TAKE   = 5'h0E;
    localparam logic [4:0] EDGE_FRAME      = 5'h10;

    // ------------------------------------------------------------------
    // Command addresses
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP    = 3'h0,
        CMD_WR_CFG = 3'h1,
        CMD_RSV2   = 3'h2,
        CMD_RSV3   = 3'h3,
        CMD_RD_ERR = 3'h4,
        CMD_RD_CFG = 3'h5,
        CMD_RSV6   = 3'h6,
        CMD_RSV7   = 3'h7
    } dcs_cmd_t;

    // ------------------------------------------------------------------
    // Register layouts and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] DEVICE_CONFIGURATION_ADDR = 3'h1;
    localparam logic [9:0] CFG_RESET       = 10'h000;
    localparam int         CFG_MODE_LSB    = 7;
    localparam int         CFG_BOTH_LSB    = 4;
    localparam int         CFG_THERM_BIT   = 3;
    localparam int         ERR_INTERM_BIT  = 9;
    localparam int         ERR_SHORT_BIT   = 8;
    localparam int         ERR_OPEN_BIT    = 7;
    localparam int         ERR_OTEMP_BIT   = 6;
    localparam int         ERR_BROWN_BIT   = 5;
    localparam int         COND_SHORT      = 0;
    localparam int         COND_OPEN       = 1;
    localparam int         COND_OTEMP      = 2;
    localparam int         COND_BROWN      = 3;
    localparam logic [3:0] COND_RESET      = 4'h0;

    // ------------------------------------------------------------------
    // Port state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } dcs_state_t;

endpackage

// ==== hw/dcs_err_if.sv ====
// Purpose: Carries error readback requests and status between port and tracker.
// Assumes: One clock domain, sys_clk_i.
// Notes:   read_req is a one-cycle pulse at the end of a complete read-error frame.
`timescale 1ns/1ps
interface dcs_err_if;
    logic       read_req;
    logic [9:0] status;
    logic       irq;

    modport port    (output read_req, input status, input irq);
    modport tracker (input read_req, output status, output irq);
endinterface

// ==== hw/dcs_sync3.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to sys_clk_i.
// Notes:   The output follows only once the second and third stages agree.
`timescale 1ns/1ps
module dcs_sync3 import dcs_pkg::*; #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rstn_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] out_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ff1_q <= RST_VAL;
            ff2_q <= RST_VAL;
            ff3_q <= RST_VAL;
        end else begin
            ff1_q <= async_i;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_q <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (ff2_q[i] == ff3_q[i]) begin
                    out_q[i] <= ff3_q[i];
                end
            end
        end
    end

    assign sync_o = out_q;
endmodule

// ==== hw/dcs_err_tracker.sv ====
// Purpose: Latches error conditions, the intermittent flag and the interrupt.
// Assumes: Conditions are already synchronised to sys_clk_i.
// Notes:   First read releases the interrupt, second read reloads the register.
`timescale 1ns/1ps
module dcs_err_tracker import dcs_pkg::*; (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    // Live error conditions
    input  wire logic [3:0] cond_i,
    // Port side
    dcs_err_if.tracker      err_if
);
    logic [3:0] err_q;
    logic [3:0] reported_q;
    logic       interm_q;
    logic       read_once_q;
    logic       irq_q;
    logic       new_evt;
    logic       reload;
    logic [1:0] gone;

    assign new_evt = |(cond_i & ~err_q & ~reported_q);
    assign reload  = err_if.read_req & read_once_q;
    // Only short circuit and open load can vanish into the intermittent flag.
    assign gone    = err_q[COND_OPEN:COND_SHORT] & ~cond_i[COND_OPEN:COND_SHORT] & ~{2{reload}};

    // ------------------------------------------------------------------
    // Error latches
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            err_q <= COND_RESET;
        end else if (reload) begin
            err_q <= cond_i;
        end else begin
            err_q <= err_q | cond_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            interm_q <= 1'b0;
        end else if (|gone) begin
            interm_q <= 1'b1;
        end else if (reload) begin
            interm_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reported_q  <= COND_RESET;
            read_once_q <= 1'b0;
        end else if (err_if.read_req) begin
            read_once_q <= ~read_once_q;
            // Resolved errors are forgotten on the second read so they can fire again.
            reported_q  <= reload ? ((reported_q | err_q) & cond_i) : (reported_q | err_q);
        end
    end

    // ------------------------------------------------------------------
    // Interrupt: a new error wins over a read in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_q <= 1'b0;
        end else if (new_evt) begin
            irq_q <= 1'b1;
        end else if (err_if.read_req) begin
            irq_q <= 1'b0;
        end
    end

    always_comb begin
        err_if.status                 = '0;
        err_if.status[ERR_INTERM_BIT] = interm_q;
        err_if.status[ERR_SHORT_BIT]  = err_q[COND_SHORT];
        err_if.status[ERR_OPEN_BIT]   = err_q[COND_OPEN];
        err_if.status[ERR_OTEMP_BIT]  = err_q[COND_OTEMP];
        err_if.status[ERR_BROWN_BIT]  = err_q[COND_BROWN];
    end

    assign err_if.irq = irq_q;
endmodule

// ==== hw/dcs_spi_port.sv ====
// Purpose: Daisy-chain serial command port with configuration and error readback.
// Assumes: Serial clock, data, selects and fault levels are asynchronous pins.
// Notes:   Bits are taken on serial clock falling edges, MSB of the command first.
//
// Functional notes
// - After the frame, serial output is released and stays released while selected.
// - A frame is valid only after exactly 16 serial clock falling edges; a configuration write still lands at edge 14.
// - Frame-done falls on the 16th falling edge, starting the next device.
// - Bits 13 to 11 are the command; bits 9 to 0 carry the data.
// - Command 0 changes nothing; output stays driven and returns zeros.
// - Command 1 writes configuration after the 14th falling edge; output held low.
// - Commands 4 and 5 return error status and configuration on bits 9 to 0.
// - Commands 2, 3, 6 and 7 behave as no operation.
// - Each error readback bit stands for one error; several may be set.
// - A short circuit or open load that clears before being read sets the intermittent flag.
// - Only short circuit and open load may set the intermittent flag.
// - The interrupt asserts only on a newly detected error condition.
// - Reading the error register releases the interrupt until a new error.
// - Port is active only while both selects are low; otherwise it resets.
// - After a complete frame, input is ignored until a select rises and falls.
// - Error bits: 9 intermittent, 8 short, 7 open, 6 overtemp, 5 brownout.
// - Configuration: mode in 9 to 7, brownout threshold 6 to 4, thermal 3.
`timescale 1ns/1ps
module dcs_spi_port import dcs_pkg::*; (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    // Serial link pins
    input  wire logic       chip_select_primary_n_i,
    input  wire logic       chip_select_chain_n_i,
    input  wire logic       sclk_i,
    input  wire logic       din_i,
    output logic            dout_o,
    output logic            dout_oe_o,
    output logic            frame_done_n_o,
    // Fault detector levels
    input  wire logic       fault_short_i,
    input  wire logic       fault_open_i,
    input  wire logic       fault_overtemp_i,
    input  wire logic       fault_brownout_i,
    // Open-drain error interrupt
    output logic            error_n_o,
    output logic            error_oe_o,
    // Configuration outputs
    output logic [2:0]      op_mode_o,
    output logic [2:0]      brownout_threshold_select_o,
    output logic            thermal_protect_en_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0]  pins_s;
    logic [3:0]  cond_s;
    logic        cs_pri_n_s;
    logic        cs_chn_n_s;
    logic        sclk_s;
    logic        din_s;

    // Link pins reset to deselected, serial clock idle high.
    dcs_sync3 #(.W(4), .RST_VAL(4'hE)) u_sync_link (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .async_i   ({chip_select_primary_n_i, chip_select_chain_n_i, sclk_i, din_i}),
        .sync_o    (pins_s)
    );

    dcs_sync3 #(.W(4), .RST_VAL(COND_RESET)) u_sync_fault (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .async_i   ({fault_brownout_i, fault_overtemp_i, fault_open_i, fault_short_i}),
        .sync_o    (cond_s)
    );

    assign cs_pri_n_s = pins_s[3];
    assign cs_chn_n_s = pins_s[2];
    assign sclk_s     = pins_s[1];
    assign din_s      = pins_s[0];

    // ------------------------------------------------------------------
    // Error tracker
    // ------------------------------------------------------------------
    dcs_err_if err_if ();

    dcs_err_tracker u_err (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .cond_i    (cond_s),
        .err_if    (err_if)
    );

    // ------------------------------------------------------------------
    // Select and serial clock edge detection
    // ------------------------------------------------------------------
    logic        selected;
    logic        sclk_prev_q;
    logic        sclk_fall;

    assign selected = ~cs_pri_n_s & ~cs_chn_n_s;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    assign sclk_fall = sclk_prev_q & ~sclk_s;

    // ------------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------------
    dcs_state_t        state_q;
    logic [EDGE_W-1:0] edge_cnt_q;
    logic [EDGE_W-1:0] edge_next;
    logic              bit_taken;
    logic              cmd_edge;
    logic              resp_edge;
    logic              cfg_edge;
    logic              frame_end;

    assign edge_next = edge_cnt_q + 5'h01;
    assign bit_taken = (state_q == ST_SHIFT) & selected & sclk_fall;

    // One-cycle strobes at the fixed edge positions of a frame.
    assign cmd_edge  = bit_taken & (edge_next == EDGE_CMD);
    assign resp_edge = bit_taken & (edge_next >= EDGE_RESP_FIRST) & (edge_next <= EDGE_RESP_LAST);
    assign cfg_edge  = bit_taken & (edge_next == EDGE_CFG_TAKE);
    assign frame_end = bit_taken & (edge_next == EDGE_FRAME);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
        end else if (!selected) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (frame_end) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            edge_cnt_q <= '0;
        end else if (state_q != ST_SHIFT || !selected) begin
            edge_cnt_q <= '0;
        end else if (sclk_fall) begin
            edge_cnt_q <= edge_next;
        end
    end

    // ------------------------------------------------------------------
    // Input shift and command decode
    // ------------------------------------------------------------------
    logic [12:0] shift_q;
    logic [13:0] shift_in;
    dcs_cmd_t    cmd_q;
    logic [9:0]  resp_q;
    logic [9:0]  cfg_q;

    assign shift_in = {shift_q, din_s};

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_q <= '0;
        end else if (bit_taken && edge_next <= EDGE_CFG_TAKE) begin
            shift_q <= shift_in[12:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_q <= CMD_NOP;
        end else if (state_q == ST_IDLE) begin
            cmd_q <= CMD_NOP;
        end else if (cmd_edge) begin
            cmd_q <= dcs_cmd_t'(shift_in[2:0]);
        end
    end

    // Response register: loaded when the command is known, shifted out MSB first.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resp_q <= '0;
        end else if (cmd_edge) begin
            case (dcs_cmd_t'(shift_in[2:0]))
                CMD_RD_ERR: begin
                    resp_q <= err_if.status;
                end
                CMD_RD_CFG: begin
                    resp_q <= cfg_q;
                end
                default: begin
                    resp_q <= '0;
                end
            endcase
        end else if (resp_edge) begin
            resp_q <= {resp_q[8:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // A frame cut after edge 14 keeps its write.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_q <= CFG_RESET;
        end else if (cfg_edge && cmd_q == CMD_WR_CFG) begin
            cfg_q <= shift_in[9:0];
        end
    end

    assign op_mode_o                   = cfg_q[CFG_MODE_LSB +: 3];
    assign brownout_threshold_select_o = cfg_q[CFG_BOTH_LSB +: 3];
    assign thermal_protect_en_o        = cfg_q[CFG_THERM_BIT];

    // ------------------------------------------------------------------
    // Serial output, frame-done and read side effect
    // ------------------------------------------------------------------
    logic dout_q;
    logic dout_oe_q;
    logic frame_done_n_q;
    logic read_req_q;
    logic error_n_q;

    // Data out is released once the frame ends.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
        end else if (!selected || state_q == ST_DONE) begin
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b1;
        end else if (bit_taken) begin
            if (frame_end) begin
                dout_q    <= 1'b0;
                dout_oe_q <= 1'b0;
            end else if (resp_edge) begin
                dout_q    <= resp_q[9];
            end else begin
                dout_q    <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_done_n_q <= 1'b1;
        end else if (!selected) begin
            frame_done_n_q <= 1'b1;
        end else if (frame_end) begin
            frame_done_n_q <= 1'b0;
        end
    end

    // Only a complete read-error frame counts as a read of the error register.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_req_q <= 1'b0;
        end else begin
            read_req_q <= frame_end && cmd_q == CMD_RD_ERR;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            error_n_q <= 1'b1;
        end else begin
            error_n_q <= 1'b0;
        end
    end

    assign err_if.read_req = read_req_q;
    assign dout_o          = dout_q;
    assign dout_oe_o       = dout_oe_q;
    assign frame_done_n_o  = frame_done_n_q;
    assign error_n_o       = error_n_q;
    assign error_oe_o      = err_if.irq;
endmodule

// ==== sim/dcs_spi_port_assertions.sv ====
// Purpose: Pin-level checks on the daisy-chain serial command port.
// Assumes: One clock domain, sys_clk_i, with asynchronous active-low reset.
// Notes:   History windows absorb the latency of the pin synchronisers.
`timescale 1ns/1ps
module dcs_spi_port_assertions (
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       chip_select_primary_n_i,
    input  wire logic       chip_select_chain_n_i,
    input  wire logic       dout_oe_o,
    input  wire logic       frame_done_n_o,
    input  wire logic       fault_short_i,
    input  wire logic       fault_open_i,
    input  wire logic       fault_overtemp_i,
    input  wire logic       fault_brownout_i,
    input  wire logic       error_n_o,
    input  wire logic       error_oe_o,
    input  wire logic [2:0] op_mode_o,
    input  wire logic [2:0] brownout_threshold_select_o,
    input  wire logic       thermal_protect_en_o
);
    logic [15:0] sel_hist_q;
    logic [15:0] rise_hist_q;
    logic [3:0]  flt_q;
    logic        sel_both;
    logic [3:0]  flt;
    assign sel_both = !chip_select_primary_n_i && !chip_select_chain_n_i;
    assign flt      = {fault_short_i, fault_open_i, fault_overtemp_i, fault_brownout_i};

    // Remembers recent selection and recent fault onsets.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_hist_q  <= 16'h0000;
            rise_hist_q <= 16'h0000;
            flt_q       <= 4'h0;
        end else begin
            sel_hist_q  <= {sel_hist_q[14:0], sel_both};
            rise_hist_q <= {rise_hist_q[14:0], |(flt & ~flt_q)};
            flt_q       <= flt;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    a_desel_release: assert property ((!sel_both)[*8] |-> !dout_oe_o && frame_done_n_o)
        else $error("port still active while deselected");
    a_done_no_drive: assert property (!frame_done_n_o |-> !dout_oe_o)
        else $error("data out driven after frame done");
    a_done_holds: assert property ($rose(frame_done_n_o) |-> !(&sel_hist_q[7:0]))
        else $error("frame done cleared while still selected");
    a_done_in_frame: assert property ($fell(frame_done_n_o) |-> |sel_hist_q)
        else $error("frame done without a selected frame");
    a_cfg_in_frame: assert property ($changed({op_mode_o, brownout_threshold_select_o,
                                               thermal_protect_en_o}) |-> |sel_hist_q)
        else $error("configuration changed outside a frame");
    a_oe_needs_sel: assert property ($rose(dout_oe_o) |-> |sel_hist_q[7:0])
        else $error("data out enabled without selection");
    a_irq_new_fault: assert property ($rose(error_oe_o) |-> |rise_hist_q)
        else $error("interrupt without a new fault");
    a_irq_drop_read: assert property ($fell(error_oe_o) |-> |sel_hist_q)
        else $error("interrupt released without a read");
    a_irq_pulls_low: assert property (error_oe_o |-> !error_n_o)
        else $error("interrupt enabled but not pulling low");

    c_frame_done: cover property ($fell(frame_done_n_o));
    c_irq_raise: cover property ($rose(error_oe_o));
    c_cfg_write: cover property ($changed(op_mode_o));
endmodule

bind dcs_spi_port dcs_spi_port_assertions dcs_spi_port_assertions_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .chip_select_primary_n_i(chip_select_primary_n_i),
    .chip_select_chain_n_i(chip_select_chain_n_i), .dout_oe_o(dout_oe_o), .frame_done_n_o(frame_done_n_o),
    .fault_short_i(fault_short_i), .fault_open_i(fault_open_i), .fault_overtemp_i(fault_overtemp_i),
    .fault_brownout_i(fault_brownout_i), .error_n_o(error_n_o), .error_oe_o(error_oe_o),
    .op_mode_o(op_mode_o), .brownout_threshold_select_o(brownout_threshold_select_o),
    .thermal_protect_en_o(thermal_protect_en_o));

// ==== sim/dcs_host_model.sv ====
// Purpose: Serial master that sends frames and samples the returned bits.
// Assumes: The data-out line carries a pull-up.
// Notes:   Serial clock idles high; bits change while it is high.
`timescale 1ns/1ps
module dcs_host_model (
    input  wire logic sys_clk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      din_o
);
    logic line;
    assign line = dout_oe_i ? dout_i : 1'b1;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o  = 1'b0;
    end

    // Sends n bits of w MSB first; got[31-k] holds the line at falling edge k+1.
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] got);
        got = 32'hFFFFFFFF;
        @(negedge sys_clk_i);
        cs_n_o = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        for (int k = 0; k < n; k++) begin
            din_o = w[31-k];
            repeat (8) @(negedge sys_clk_i);
            sclk_o = 1'b0;
            got[31-k] = line;
            repeat (8) @(negedge sys_clk_i);
            sclk_o = 1'b1;
        end
        repeat (8) @(negedge sys_clk_i);
        cs_n_o = 1'b1;
        din_o  = ~din_o;
        repeat (10) @(negedge sys_clk_i);
    endtask
endmodule

// ==== sim/dcs_spi_port_bench.sv ====
// Purpose: Self-checking bench for the daisy-chain serial command port.
// Assumes: Inputs change on the falling system clock edge.
// Notes:   Error reads come in groups of four so read parity stays known.
`timescale 1ns/1ps
module dcs_spi_port_bench import dcs_pkg::*;;
    logic       sys_clk_i, rstn_i, cs1_n, cs2_n, sclk, din, dout, dout_oe, done_n;
    logic       error_n, error_oe, therm, done_seen;
    logic [3:0] faults;
    logic [2:0] mode, both;
    int         n_fail, samples_checked;
    logic [31:0] w1, w2, g;
    logic [9:0]  r;
    logic [2:0]  nops [5] = '{CMD_NOP, CMD_RSV2, CMD_RSV3, CMD_RSV6, CMD_RSV7};

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(negedge sys_clk_i) if (done_n === 1'b0) done_seen = 1'b1;

    dcs_spi_port dcs_spi_port_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .chip_select_primary_n_i(cs1_n),
        .chip_select_chain_n_i(cs2_n), .sclk_i(sclk), .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe),
        .frame_done_n_o(done_n), .fault_short_i(faults[3]), .fault_open_i(faults[2]),
        .fault_overtemp_i(faults[1]), .fault_brownout_i(faults[0]), .error_n_o(error_n),
        .error_oe_o(error_oe), .op_mode_o(mode), .brownout_threshold_select_o(both),
        .thermal_protect_en_o(therm));
    dcs_host_model dcs_host_model_i (.sys_clk_i(sys_clk_i), .dout_i(dout), .dout_oe_i(dout_oe),
        .cs_n_o(cs1_n), .sclk_o(sclk), .din_o(din));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] wd(input logic [2:0] c, input logic [9:0] d);
        return {c, 1'b0, d, 2'b00, 16'h0000};
    endfunction

    task automatic frm(input logic [2:0] c, input logic [9:0] d, input int n);
        done_seen = 1'b0;
        dcs_host_model_i.xfer(wd(c, d), n, g);
        r = g[27:18];
    endtask

    task automatic cfg_chk(input logic [9:0] e);
        frm(CMD_RD_CFG, 10'h000, 16);
        chk({22'h0, r}, {22'h0, e});
        chk({25'h0, mode, both, therm}, {25'h0, e[9:3]});
    endtask

    task automatic episode(input logic [3:0] f, input logic keep, input logic [9:0] e1, input logic [9:0] e2);
        faults = f;
        repeat (12) @(negedge sys_clk_i);
        chk({31'h0, error_oe}, 32'h1);
        if (!keep) faults = 4'h0;
        repeat (12) @(negedge sys_clk_i);
        frm(CMD_RD_ERR, 10'h000, 16);
        chk({22'h0, r}, {22'h0, e1});
        repeat (20) @(negedge sys_clk_i);
        chk({31'h0, error_oe}, 32'h0);
        faults = 4'h0;
        repeat (12) @(negedge sys_clk_i);
        frm(CMD_RD_ERR, 10'h000, 16);
        chk({22'h0, r}, {22'h0, e2});
        frm(CMD_RD_ERR, 10'h000, 16);
        frm(CMD_RD_ERR, 10'h000, 16);
        chk({22'h0, r}, 32'h0);
    endtask

    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #400us;
        n_fail++;
        finish_test();
    end

    initial begin
        n_fail = 0;
        samples_checked = 0;
        rstn_i = 1'b0;
        cs2_n = 1'b1;
        faults = 4'h0;
        done_seen = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        cs2_n = 1'b0;
        cfg_chk(CFG_RESET);
        // ------------------------------------------------------------
        // Extended frame: first write lands, the second half is ignored.
        // ------------------------------------------------------------
        w1 = wd(CMD_WR_CFG, 10'h3A8);
        w2 = wd(CMD_WR_CFG, 10'h155);
        dcs_host_model_i.xfer({w1[31:16], w2[31:16]}, 32, g);
        chk({22'h0, g[27:18]}, 32'h0);
        chk({16'h0, g[15:0]}, 32'h0000FFFF);
        cfg_chk(10'h3A8);
        // ------------------------------------------------------------
        // No-op and reserved commands, short and unselected frames.
        // ------------------------------------------------------------
        for (int i = 0; i < 5; i++) begin
            frm(nops[i], 10'h001, 16);
            if (i == 0) chk({22'h0, r}, 32'h0);
        end
        frm(CMD_WR_CFG, 10'h000, 13);
        chk({31'h0, done_seen}, 32'h0);
        cs2_n = 1'b1;
        frm(CMD_WR_CFG, 10'h000, 16);
        chk({31'h0, done_seen}, 32'h0);
        cs2_n = 1'b0;
        cfg_chk(10'h3A8);
        chk({31'h0, done_seen}, 32'h1);
        // ------------------------------------------------------------
        // Error episodes: transient short, transient overtemp, lasting pair.
        // ------------------------------------------------------------
        episode(4'b1000, 1'b0, 10'h300, 10'h300);
        episode(4'b0010, 1'b0, 10'h040, 10'h040);
        episode(4'b0101, 1'b1, 10'h0A0, 10'h2A0);
        cfg_chk(10'h3A8);
        frm(CMD_WR_CFG, 10'h157, 16);
        cfg_chk(10'h157);
        finish_test();
    end
endmodule
